//--- ptg_defs.vh
// Constants for the pulse train generator: offsets, fields, reset values, timing
`ifndef PTG_DEFS_VH
`define PTG_DEFS_VH

// ****************************************************************************
// Clock and timing
// ****************************************************************************
`define PTG_CLK_HZ        20000000
`define PTG_CLK_MHZ       20
`define PTG_TICK_US       1000
`define PTG_TICK_CYC      (`PTG_TICK_US * `PTG_CLK_MHZ)
`define PTG_PCT_CYC       (`PTG_CLK_HZ / 100)

// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define PTG_OFF_CTRL      8'h00
`define PTG_OFF_FREQ      8'h04
`define PTG_OFF_COUNT     8'h08
`define PTG_OFF_DUTY      8'h0C
`define PTG_OFF_ENDF      8'h10
`define PTG_OFF_RAMPMS    8'h14
`define PTG_OFF_SEGS      8'h18
`define PTG_OFF_STAT      8'h1C
`define PTG_OFF_PULSES    8'h20

// ****************************************************************************
// Control fields
// ****************************************************************************
`define PTG_CTRL_MODE_LO  0
`define PTG_CTRL_MODE_HI  1
`define PTG_CTRL_OSEL     2
`define PTG_CTRL_HSEN     3
`define PTG_CTRL_TRIG     8
`define PTG_CTRL_STOP     9

`define PTG_MODE_FIXED    2'h0
`define PTG_MODE_PWM      2'h1
`define PTG_MODE_RAMP     2'h2

// ****************************************************************************
// Reset values
// ****************************************************************************
`define PTG_RST_FREQ      17'h0_03E8
`define PTG_RST_COUNT     27'h000_0000
`define PTG_RST_DUTY      7'h32
`define PTG_RST_RAMPMS    13'h0064
`define PTG_RST_SEGS      7'h0A

`endif

//--- ptg_pulse_train.v
// Triggerable pulse train generator with fixed, modulated and ramped modes
`timescale 1ns/1ps
`default_nettype none
`include "ptg_defs.vh"

// Functional notes
// - Trigger starts the configured train in every mode
// - Reset input stops generation and returns block to idle
// - Fixed mode gives a 50 percent square wave
// - Pulse count zero means continuous output at set frequency
// - Independent mode obeys count and frequency; continuous ignores count
// - Frequency setting accepts 1 to 100000 Hz
// - Pulse count accepts 0 to 99999999
// - Modulated duty accepts 10 to 100 percent; high phase follows it
// - Modulated output follows count, frequency and duty
// - In ramped mode trigger starts the ramped output
// - Ramp start and end frequencies accept 1 to 100000 Hz
// - Ramp time 10 to 5000 ms; segments 1 to 100
// - Ramped total pulse count accepts 1 to 99999999
// - Each segment lasts ramp time over segment count
// - Frequency step is end minus start over segments less one; the code uses zero when end is not above start or segments is 1
// - Pulses per segment equal segment time over segment period
// - Ramped train accelerates then decelerates per its parameters
// - Running pulse count is published continuously as word data
module ptg_pulse_train #(
  parameter integer CLK_HZ   = `PTG_CLK_HZ,
  parameter integer TICK_CYC = `PTG_TICK_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Trigger and stop pins
  input  wire        trig_i,
  input  wire        stop_i,
  // Waveform and status
  output reg         fast_output_a_o,
  output reg         fast_output_b_o,
  output reg  [26:0] word_data_register_o,
  output reg         busy_o
);

  // ****************************************************************************
  // States and phases
  // ****************************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CALC = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  localparam [2:0] PH_ACC  = 3'b001;
  localparam [2:0] PH_CRU  = 3'b010;
  localparam [2:0] PH_DEC  = 3'b100;

  // Integer forms first, so the narrowing below is deliberate
  localparam integer HALF_I     = CLK_HZ / 2;
  localparam integer PCT_I      = CLK_HZ / 100;
  localparam integer TICK_TOP_I = TICK_CYC - 1;

  localparam [24:0] WRAP     = CLK_HZ[24:0];
  localparam [24:0] HALF     = HALF_I[24:0];
  localparam [24:0] PCT      = PCT_I[24:0];
  localparam [14:0] TICK_TOP = TICK_TOP_I[14:0];

  // ****************************************************************************
  // Configuration registers
  // ****************************************************************************
  reg  [1:0]  mode_r;
  reg         osel_r;
  reg         hsen_r;
  reg  [16:0] freq_cfg_r;
  reg  [26:0] count_cfg_r;
  reg  [6:0]  duty_cfg_r;
  reg  [16:0] endf_cfg_r;
  reg  [12:0] rampms_cfg_r;
  reg  [6:0]  segs_cfg_r;

  // ****************************************************************************
  // Run state
  // ****************************************************************************
  reg  [2:0]  state_r;
  reg  [2:0]  phase_r;
  reg         done_r;
  reg         trig_q_r;
  reg  [24:0] acc_r;
  reg  [24:0] thr_r;
  reg  [16:0] freq_r;
  reg  [16:0] top_r;
  reg  [16:0] step_r;
  reg  [16:0] quo_r;
  reg  [6:0]  rem_r;
  reg  [4:0]  div_cnt_r;
  reg  [26:0] pulses_r;
  reg  [26:0] acc_pulses_r;
  reg  [14:0] tick_cnt_r;
  reg  [13:0] seg_acc_r;
  reg  [6:0]  seg_idx_r;

  // ****************************************************************************
  // Bus decode
  // ****************************************************************************
  wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr      = req & wb_we_i;
  wire [31:0] wmask;
  wire        wr_ctrl = wr & (wb_adr_i == `PTG_OFF_CTRL);

  // ****************************************************************************
  // Byte lanes
  // ****************************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wmask[8*g+7:8*g] = {8{wb_sel_i[g]}};
    end
  endgenerate

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  wire [31:0] ctrl_rd = {28'h000_0000, hsen_r, osel_r, mode_r};
  wire [31:0] ctrl_wv = merge(ctrl_rd, wb_dat_i, wmask);

  // Full-width merges; each register then keeps only its own low bits
  wire [31:0] freq_wv   = merge({15'h0000, freq_cfg_r}, wb_dat_i, wmask);
  wire [31:0] count_wv  = merge({5'h00, count_cfg_r}, wb_dat_i, wmask);
  wire [31:0] duty_wv   = merge({25'h000_0000, duty_cfg_r}, wb_dat_i, wmask);
  wire [31:0] endf_wv   = merge({15'h0000, endf_cfg_r}, wb_dat_i, wmask);
  wire [31:0] rampms_wv = merge({19'h0_0000, rampms_cfg_r}, wb_dat_i, wmask);
  wire [31:0] segs_wv   = merge({25'h000_0000, segs_cfg_r}, wb_dat_i, wmask);

  // Software strobes act only on a byte lane that was written
  wire sw_trig = wr_ctrl & wb_sel_i[1] & wb_dat_i[`PTG_CTRL_TRIG];
  wire sw_stop = wr_ctrl & wb_sel_i[1] & wb_dat_i[`PTG_CTRL_STOP];

  // ****************************************************************************
  // Start, stop and waveform arithmetic
  // ****************************************************************************
  wire is_ramp   = (mode_r == `PTG_MODE_RAMP);
  wire stop_now  = stop_i | sw_stop;
  // Starting without high-speed running enabled is refused
  wire start_now = ((trig_i & ~trig_q_r) | sw_trig) & hsen_r
                   & ~stop_now & state_r[0];

  wire [25:0] sum     = {1'b0, acc_r} + {9'h000, freq_r};
  wire        wrap    = (sum >= {1'b0, WRAP});
  wire [25:0] sum_wr  = sum - {1'b0, WRAP};
  // Modulated threshold; a duty above 100 percent simply stays high
  wire [24:0] pwm_thr = duty_cfg_r * PCT;
  wire [26:0] pls_inc = pulses_r + 27'h000_0001;
  // Count zero runs continuously in any mode
  wire        finish  = wrap & (count_cfg_r != 27'h000_0000)
                        & (pls_inc == count_cfg_r);
  wire        run_on  = state_r[2] & ~stop_now & ~finish;

  wire        tick    = (tick_cnt_r == TICK_TOP);
  wire [13:0] seg_sum = seg_acc_r + {7'h00, segs_cfg_r};
  // Segments end on an average of ramp time over segment count
  wire        seg_end = tick & (seg_sum >= {1'b0, rampms_cfg_r});
  // Overshoot carries into the next segment so the average holds
  wire [13:0] seg_rem = seg_sum - {1'b0, rampms_cfg_r};

  // Restoring divider: one quotient bit per cycle, no divider array
  wire [6:0]  divisor = segs_cfg_r - 7'h01;
  wire [16:0] diff    = (endf_cfg_r > freq_cfg_r) ? (endf_cfg_r - freq_cfg_r) : 17'h0_0000;
  wire [7:0]  trial   = {rem_r, quo_r[16]};
  wire        fits    = (trial >= {1'b0, divisor});
  wire [7:0]  trial_s = trial - {1'b0, divisor};

  // ****************************************************************************
  // Wishbone slave and configuration
  // ****************************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      mode_r       <= `PTG_MODE_FIXED;
      osel_r       <= 1'b0;
      hsen_r       <= 1'b0;
      freq_cfg_r   <= `PTG_RST_FREQ;
      count_cfg_r  <= `PTG_RST_COUNT;
      duty_cfg_r   <= `PTG_RST_DUTY;
      endf_cfg_r   <= `PTG_RST_FREQ;
      rampms_cfg_r <= `PTG_RST_RAMPMS;
      segs_cfg_r   <= `PTG_RST_SEGS;
    end else begin
      wb_ack_o <= req;
      if (wr) begin
        case (wb_adr_i)
          `PTG_OFF_CTRL: begin
            mode_r <= ctrl_wv[`PTG_CTRL_MODE_HI:`PTG_CTRL_MODE_LO];
            osel_r <= ctrl_wv[`PTG_CTRL_OSEL];
            hsen_r <= ctrl_wv[`PTG_CTRL_HSEN];
          end
          `PTG_OFF_FREQ:   freq_cfg_r   <= freq_wv[16:0];
          `PTG_OFF_COUNT:  count_cfg_r  <= count_wv[26:0];
          `PTG_OFF_DUTY:   duty_cfg_r   <= duty_wv[6:0];
          `PTG_OFF_ENDF:   endf_cfg_r   <= endf_wv[16:0];
          `PTG_OFF_RAMPMS: rampms_cfg_r <= rampms_wv[12:0];
          `PTG_OFF_SEGS:   segs_cfg_r   <= segs_wv[6:0];
          default: ;
        endcase
      end
      if (req & ~wb_we_i) begin
        case (wb_adr_i)
          `PTG_OFF_CTRL:   wb_dat_o <= ctrl_rd;
          `PTG_OFF_FREQ:   wb_dat_o <= {15'h0000, freq_cfg_r};
          `PTG_OFF_COUNT:  wb_dat_o <= {5'h00, count_cfg_r};
          `PTG_OFF_DUTY:   wb_dat_o <= {25'h000_0000, duty_cfg_r};
          `PTG_OFF_ENDF:   wb_dat_o <= {15'h0000, endf_cfg_r};
          `PTG_OFF_RAMPMS: wb_dat_o <= {19'h0_0000, rampms_cfg_r};
          `PTG_OFF_SEGS:   wb_dat_o <= {25'h000_0000, segs_cfg_r};
          `PTG_OFF_STAT:   wb_dat_o <= {27'h000_0000, phase_r, done_r, ~state_r[0]};
          `PTG_OFF_PULSES: wb_dat_o <= {5'h00, pulses_r};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************************
  // Train sequencer
  // ****************************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= ST_IDLE;
      phase_r      <= PH_ACC;
      done_r       <= 1'b0;
      trig_q_r     <= 1'b0;
      acc_r        <= 25'h000_0000;
      thr_r        <= 25'h000_0000;
      freq_r       <= 17'h0_0000;
      top_r        <= 17'h0_0000;
      step_r       <= 17'h0_0000;
      quo_r        <= 17'h0_0000;
      rem_r        <= 7'h00;
      div_cnt_r    <= 5'h00;
      pulses_r     <= 27'h000_0000;
      acc_pulses_r <= 27'h000_0000;
      tick_cnt_r   <= 15'h0000;
      seg_acc_r    <= 14'h0000;
      seg_idx_r    <= 7'h00;
    end else begin
      trig_q_r <= trig_i;
      case (state_r)
        ST_IDLE: begin
          if (start_now) begin
            done_r       <= 1'b0;
            pulses_r     <= 27'h000_0000;
            acc_pulses_r <= 27'h000_0000;
            acc_r        <= 25'h000_0000;
            freq_r       <= freq_cfg_r;
            phase_r      <= PH_ACC;
            seg_idx_r    <= 7'h00;
            seg_acc_r    <= 14'h0000;
            tick_cnt_r   <= 15'h0000;
            quo_r        <= diff;
            rem_r        <= 7'h00;
            div_cnt_r    <= 5'h11;
            // Ramped and fixed trains are always square
            if (mode_r == `PTG_MODE_PWM)
              thr_r <= pwm_thr;
            else
              thr_r <= HALF;
            state_r <= is_ramp ? ST_CALC : ST_RUN;
          end
        end
        ST_CALC: begin
          // Step division runs once per trigger, 17 cycles
          if (stop_now) begin
            state_r <= ST_IDLE;
          end else if (div_cnt_r == 5'h00) begin
            step_r  <= (divisor == 7'h00) ? 17'h0_0000 : quo_r;
            state_r <= ST_RUN;
          end else begin
            div_cnt_r <= div_cnt_r - 5'h01;
            quo_r     <= {quo_r[15:0], fits};
            rem_r     <= fits ? trial_s[6:0] : trial[6:0];
          end
        end
        ST_RUN: begin
          acc_r <= wrap ? sum_wr[24:0] : sum[24:0];
          if (wrap)
            pulses_r <= pls_inc;
          if (stop_now) begin
            state_r <= ST_IDLE;
          end else if (finish) begin
            state_r <= ST_IDLE;
            done_r  <= 1'b1;
          end else if (is_ramp) begin
            tick_cnt_r <= tick ? 15'h0000 : tick_cnt_r + 15'h0001;
            if (tick)
              seg_acc_r <= seg_end ? seg_rem : seg_sum;
            case (phase_r)
              PH_ACC: begin
                // Half the budget spent: turn round where we stand
                if ((count_cfg_r != 27'h000_0000) && ({pulses_r, 1'b0} >= {1'b0, count_cfg_r})) begin
                  phase_r   <= PH_DEC;
                  seg_acc_r <= 14'h0000;
                end else if (seg_end) begin
                  if (seg_idx_r < divisor) begin
                    seg_idx_r <= seg_idx_r + 7'h01;
                    freq_r    <= freq_r + step_r;
                  end else begin
                    phase_r      <= PH_CRU;
                    top_r        <= freq_r;
                    acc_pulses_r <= pulses_r;
                  end
                end
              end
              PH_CRU: begin
                // Cruise at the end frequency until the mirror budget is reached
                freq_r <= endf_cfg_r;
                if ((count_cfg_r != 27'h000_0000) && (pulses_r + acc_pulses_r >= count_cfg_r)) begin
                  phase_r   <= PH_DEC;
                  freq_r    <= top_r;
                  seg_acc_r <= 14'h0000;
                end
              end
              PH_DEC: begin
                if (seg_end && (seg_idx_r != 7'h00)) begin
                  seg_idx_r <= seg_idx_r - 7'h01;
                  freq_r    <= freq_r - step_r;
                end
              end
              default: phase_r <= PH_ACC;
            endcase
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************************
  // Registered outputs
  // ****************************************************************************
  // Only the selected fast output ever carries the train
  always @(posedge clk_i) begin
    if (rst_i) begin
      fast_output_a_o      <= 1'b0;
      fast_output_b_o      <= 1'b0;
      word_data_register_o <= 27'h000_0000;
      busy_o               <= 1'b0;
    end else begin
      fast_output_a_o      <= run_on & (acc_r < thr_r) & ~osel_r;
      fast_output_b_o      <= run_on & (acc_r < thr_r) & osel_r;
      word_data_register_o <= pulses_r;
      busy_o               <= start_now | (~state_r[0] & ~stop_now & ~finish);
    end
  end

endmodule // ptg_pulse_train
`default_nettype wire

//--- ptg_pulse_train_props.sv
// Port checker for the pulse train generator
`timescale 1ns/1ps
`default_nettype none
module ptg_pulse_train_props (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Register bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Pins and waveform
  input wire        trig_i,
  input wire        stop_i,
  input wire        fast_output_a_o,
  input wire        fast_output_b_o,
  input wire [26:0] word_data_register_o,
  input wire        busy_o
);
  // ****
  // Properties
  // ****
  wire req = wb_cyc_i && wb_stb_i;
  wire out_low = !fast_output_a_o && !fast_output_b_o;
  // The bus holds a taken write into the ack cycle, so one past sample covers both launch edges
  wire wr_trig = req && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[8];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_due; req && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_cause; !req |=> !wb_ack_o; endproperty
  property p_stop; stop_i |=> !busy_o && out_low; endproperty
  property p_stop_wins; stop_i && $rose(trig_i) |=> !busy_o ##1 !busy_o; endproperty
  property p_start; $rose(busy_o) |-> ($past(trig_i) && !$past(trig_i, 2)) || $past(wr_trig); endproperty
  property p_idle_low; !busy_o && !$past(busy_o) |-> out_low; endproperty
  property p_wd_hold; !busy_o [*3] |-> $stable(word_data_register_o); endproperty
  property p_wd_step;
    busy_o |=> word_data_register_o == 27'h000_0000 || word_data_register_o == $past(word_data_register_o)
      || word_data_register_o == $past(word_data_register_o) + 27'h000_0001;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_ack_due: assert property (p_ack_due) else $error("request not acked next cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_stop: assert property (p_stop) else $error("stop did not idle the block");
  a_stop_wins: assert property (p_stop_wins) else $error("trigger beat stop");
  a_start: assert property (p_start) else $error("train started without trigger");
  a_idle_low: assert property (p_idle_low) else $error("output high while idle");
  a_wd_hold: assert property (p_wd_hold) else $error("word data moved while idle");
  a_wd_step: assert property (p_wd_step) else $error("word data jumped");
  c_done: cover property ($fell(busy_o));
  c_stop: cover property (stop_i && busy_o);
  c_out_b: cover property ($rose(fast_output_b_o));
endmodule // ptg_pulse_train_props
bind ptg_pulse_train ptg_pulse_train_props i_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trig_i(trig_i), .stop_i(stop_i), .fast_output_a_o(fast_output_a_o),
  .fast_output_b_o(fast_output_b_o), .word_data_register_o(word_data_register_o), .busy_o(busy_o)
);
`default_nettype wire

//--- ptg_actuator_model.sv
// Actuator model on the fast outputs: counts pulses, times the high phase
`timescale 1ns/1ps
`default_nettype none
module ptg_actuator_model (
  // Clock and clear
  input  wire        clk_i,
  input  wire        clr_i,
  // Drive lines
  input  wire        drive_a_i,
  input  wire        drive_b_i,
  // Observations
  output logic [7:0] cnt_a_o,
  output logic [7:0] cnt_b_o,
  output logic [7:0] high_len_o
);
  logic [7:0] run_r;
  logic       a_r;
  logic       b_r;
  // Pulse counts on its rising edge; width latched when it falls
  always @(posedge clk_i) begin
    a_r <= drive_a_i;
    b_r <= drive_b_i;
    run_r <= (drive_a_i || drive_b_i) ? run_r + 8'h01 : 8'h00;
    if (!drive_a_i && !drive_b_i && (a_r || b_r)) high_len_o <= run_r;
    if (clr_i) begin
      cnt_a_o <= 8'h00;
      cnt_b_o <= 8'h00;
    end else begin
      cnt_a_o <= cnt_a_o + 8'(drive_a_i && !a_r);
      cnt_b_o <= cnt_b_o + 8'(drive_b_i && !b_r);
    end
  end
endmodule // ptg_actuator_model
`default_nettype wire

//--- ptg_pulse_train_tb.sv
// Self-checking bench for the pulse train generator
`timescale 1ns/1ps
`default_nettype none
module ptg_pulse_train_tb;
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, trig_i, stop_i, clr;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  wire  [31:0] wb_dat_o;
  wire  [26:0] word_data_register_o;
  wire         wb_ack_o, fast_output_a_o, fast_output_b_o, busy_o;
  wire  [7:0]  ca, cb, hl;
  int          num_errors = 0;
  int          n_compared = 0;
  int          seed = 89;
  int          n, i;
  logic        prev_busy = 1'b0;
  logic [31:0] exp_rd[$];
  logic [23:0] exp_run[$];
  logic [7:0]  tab_adr [0:9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
  logic [15:0] tab_val [0:9] = '{16'h0000, 16'h03E8, 16'h0000, 16'h0032, 16'h03E8, 16'h0064, 16'h000A,
                                 16'h0004, 16'h0000, 16'h0000};
  // Small clock so that 100 Hz gives a 20-cycle period
  ptg_pulse_train #(.CLK_HZ(2000), .TICK_CYC(20)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .trig_i(trig_i), .stop_i(stop_i), .fast_output_a_o(fast_output_a_o),
    .fast_output_b_o(fast_output_b_o), .word_data_register_o(word_data_register_o), .busy_o(busy_o));
  ptg_actuator_model i_act (.clk_i(clk_i), .clr_i(clr), .drive_a_i(fast_output_a_o),
    .drive_b_i(fast_output_b_o), .cnt_a_o(ca), .cnt_b_o(cb), .high_len_o(hl));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for the answer
    do @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic run(input logic [31:0] ctrl, input logic [23:0] e, input logic pin);
    int t;
    exp_run.push_back(e);
    clr <= 1'b1;
    wb(8'h00, 1'b1, ctrl);
    clr <= 1'b0;
    if (pin) begin
      trig_i <= 1'b1;
      @(posedge clk_i);
      trig_i <= 1'b0;
    end
    else wb(8'h00, 1'b1, ctrl | 32'h0000_0100);
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while ((busy_o === 1'b1 || t < 3) && t < 5000);
    if (t >= 5000) num_errors++;
  endtask
  task stop_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****
  // Clock, monitor, watchdog
  // ****
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    prev_busy <= busy_o;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_rd.size() > 0) chk(wb_dat_o, exp_rd.pop_front());
    if (prev_busy === 1'b1 && busy_o === 1'b0 && exp_run.size() > 0)
      chk({8'h00, hl, ca, cb}, {8'h00, exp_run.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, trig_i, stop_i, clr} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 10; i++) rd(tab_adr[i], {16'h0000, tab_val[i]});
    n = 2 + {$random(seed)} % 3;
    wb(8'h04, 1'b1, 32'h0000_0064);
    wb(8'h08, 1'b1, 32'(n));
    run(32'h0000_0008, {8'h0A, n[7:0], 8'h00}, 1'b1);
    rd(8'h20, 32'(n));
    chk({5'h00, word_data_register_o}, 32'(n));
    rd(8'h1C, 32'h0000_0006);
    wb(8'h20, 1'b1, 32'h0000_00FF);
    rd(8'h20, 32'(n));
    wb(8'h40, 1'b1, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    wb(8'h0C, 1'b1, 32'h0000_0019);
    wb(8'h08, 1'b1, 32'h0000_0002);
    run(32'h0000_000D, {8'h05, 8'h00, 8'h02}, 1'b1);
    // Start equals end and each 5 ms segment spans several periods
    wb(8'h10, 1'b1, 32'h0000_0064);
    wb(8'h14, 1'b1, 32'h0000_000A);
    wb(8'h18, 1'b1, 32'h0000_0002);
    wb(8'h08, 1'b1, 32'h0000_0006);
    run(32'h0000_000A, {8'h0A, 8'h06, 8'h00}, 1'b0);
    clr <= 1'b1;
    wb(8'h08, 1'b1, 32'h0000_0000);
    clr <= 1'b0;
    wb(8'h00, 1'b1, 32'h0000_0108);
    repeat (300) @(posedge clk_i);
    chk(32'(busy_o), 32'h0000_0001);
    chk(32'(ca >= 8'h0E), 32'h0000_0001);
    stop_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'({busy_o, fast_output_a_o, fast_output_b_o}), 32'h0000_0000);
    trig_i <= 1'b1;
    @(posedge clk_i);
    trig_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(busy_o), 32'h0000_0000);
    stop_i <= 1'b0;
    wb(8'h00, 1'b1, 32'h0000_0108);
    chk(32'(busy_o), 32'h0000_0001);
    wb(8'h00, 1'b1, 32'h0000_0208);
    chk(32'(busy_o), 32'h0000_0000);
    // Clear the enable first: a trigger is judged against the enable already held
    wb(8'h00, 1'b1, 32'h0000_0000);
    wb(8'h00, 1'b1, 32'h0000_0100);
    repeat (2) @(posedge clk_i);
    chk(32'(busy_o), 32'h0000_0000);
    repeat (5) @(posedge clk_i);
    stop_test;
  end
endmodule // ptg_pulse_train_tb
`default_nettype wire
